/* File: rtl/kwup_pkg.sv */
// package for the key wake-up port block
package kwup_pkg;
   localparam logic [7:0] KWUP_ADDR_G_DATA = 8'h28;
   localparam logic [7:0] KWUP_ADDR_H_DATA = 8'h29;
   localparam logic [7:0] KWUP_ADDR_G_DIR = 8'h2a;
   localparam logic [7:0] KWUP_ADDR_H_DIR = 8'h2b;
   localparam logic [7:0] KWUP_ADDR_G_WEN = 8'h2c;
   localparam logic [7:0] KWUP_ADDR_H_WEN = 8'h2d;
   localparam logic [7:0] KWUP_ADDR_G_WFL = 8'h2e;
   localparam logic [7:0] KWUP_ADDR_H_WFL = 8'h2f;
   localparam logic [7:0] KWUP_ADDR_MODE = 8'h30;
   localparam logic [7:0] KWUP_RST_BYTE = 8'h00;
   localparam int KWUP_I2C_SEL_BIT = 7;
   localparam int KWUP_SDA_BIT = 6;
   localparam int KWUP_SCL_BIT = 7;
   localparam int KWUP_STOP_BIT = 0;
   localparam logic [7:0] KWUP_G_WAKE_MASK = 8'h7f;
   localparam logic [7:0] KWUP_H_WAKE_MASK = 8'hff;
   // filter oscillator period in ns, and cycles of clk_sys at 50 MHz
   localparam int KWUP_CLK_NS = 20;
   localparam int KWUP_FOSC_NS = 200;
   localparam int KWUP_FOSC_CYC = KWUP_FOSC_NS / KWUP_CLK_NS;
   localparam int KWUP_SAMPLE_CYC = KWUP_FOSC_CYC / 3;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } kwup_bus_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull_up;
      logic [7:0] pull_dn;
   } kwup_pins_t;

   typedef enum logic [1:0] {
      KWUP_F_IDLE = 2'b00,
      KWUP_F_SAMPLE = 2'b01,
      KWUP_F_DECIDE = 2'b10
   } kwup_fstate_t;
endpackage

/* File: rtl/kwup_ports.sv */
// two 8-bit ports with key wake-up flags, filter and register port
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module kwup_ports
   import kwup_pkg::*;
#(
   parameter int FOSC_CYC = KWUP_FOSC_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire kwup_bus_t bus,
   output logic [7:0] rd_data,
   input wire logic [7:0] g_pin_in,
   input wire logic [7:0] h_pin_in,
   input wire logic g_pull_select_pin,
   input wire logic h_pull_select_pin,
   output kwup_pins_t g_pins,
   output kwup_pins_t h_pins,
   output logic wake_irq
);
   logic [7:0] g_data_q, h_data_q, g_dir_q, h_dir_q, g_wen_q, h_wen_q;
   logic [7:0] g_wfl_q, h_wfl_q, g_wfl_d, h_wfl_d;
   logic stop_q;
   logic [7:0] g_prev_q, h_prev_q;
   logic [7:0] g_fall, h_fall;
   logic [7:0] g_ev, h_ev;
   logic i2c_sel;
   logic g_pend, h_pend;

   // enabled falling edges of the pins that may wake the part
   function automatic logic [7:0] armed(input logic [7:0] ev, input logic [7:0] en,
         input logic [7:0] mask);
      return ev & en & mask;
   endfunction

   // pull enable on input pins when the select level matches the pull sense
   function automatic logic [7:0] pull_mask(input logic sel, input logic up,
         input logic [7:0] dir);
      return {8{sel == up}} & ~dir;
   endfunction

   // drive enable of a pin that may be open-drain: released while high
   function automatic logic drive_en(input logic dir, input logic data, input logic od);
      return dir & ~(od & data);
   endfunction

   function automatic logic hit(input logic [7:0] a);
      return bus.addr == a;
   endfunction

   assign i2c_sel = g_wen_q[KWUP_I2C_SEL_BIT];

   // data registers, open to software at any time
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         g_data_q <= KWUP_RST_BYTE;
      end else if (bus.wr && hit(KWUP_ADDR_G_DATA)) begin
         g_data_q <= bus.wdata;
      end
   end

   // port H data
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         h_data_q <= KWUP_RST_BYTE;
      end else if (bus.wr && hit(KWUP_ADDR_H_DATA)) begin
         h_data_q <= bus.wdata;
      end
   end

   // direction registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         g_dir_q <= KWUP_RST_BYTE;
      end else if (bus.wr && hit(KWUP_ADDR_G_DIR)) begin
         g_dir_q <= bus.wdata;
      end
   end

   // port H direction
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         h_dir_q <= KWUP_RST_BYTE;
      end else if (bus.wr && hit(KWUP_ADDR_H_DIR)) begin
         h_dir_q <= bus.wdata;
      end
   end

   // wake enables; bit 7 of port G selects start detection
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         g_wen_q <= KWUP_RST_BYTE;
      end else if (bus.wr && hit(KWUP_ADDR_G_WEN)) begin
         g_wen_q <= bus.wdata;
      end
   end

   // port H wake enables
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         h_wen_q <= KWUP_RST_BYTE;
      end else if (bus.wr && hit(KWUP_ADDR_H_WEN)) begin
         h_wen_q <= bus.wdata;
      end
   end

   // mode register: low bit holds STOP
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         stop_q <= 1'b0;
      end else if (bus.wr && hit(KWUP_ADDR_MODE)) begin
         stop_q <= bus.wdata[KWUP_STOP_BIT];
      end
   end

   // filter: oscillator divider and majority vote over three samples
   kwup_fstate_t fst_q;
   logic [15:0] fcnt_q;
   logic [1:0] fsmp_q;
   logic [7:0] g_arm_q, h_arm_q;
   logic [7:0] g_fok, h_fok;
   logic [7:0] g_new, h_new;
   logic f_start;
   logic f_tick;
   logic f_last;
   logic [15:0] smp_cyc;
   assign smp_cyc = 16'(FOSC_CYC / 3 > 0 ? FOSC_CYC / 3 : 1);
   assign f_tick = fcnt_q == smp_cyc - 16'h0001;
   assign f_last = f_tick && fsmp_q == 2'b10;
   assign g_new = armed(g_fall, g_wen_q, KWUP_G_WAKE_MASK);
   assign h_new = armed(h_fall, h_wen_q, KWUP_H_WAKE_MASK);
   // enabled falling edge starts the oscillator
   assign f_start = stop_q && (g_new != 8'h00 || h_new != 8'h00);

   // filter state: idle, three samples, then the vote
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         fst_q <= KWUP_F_IDLE;
      end else begin
         case (fst_q)
            KWUP_F_IDLE: begin
               if (f_start) fst_q <= KWUP_F_SAMPLE;
            end
            KWUP_F_SAMPLE: begin
               if (f_last) fst_q <= KWUP_F_DECIDE;
            end
            KWUP_F_DECIDE: fst_q <= KWUP_F_IDLE;
            default: fst_q <= KWUP_F_IDLE;
         endcase
      end
   end

   // divider runs only while sampling
   always_ff @(posedge clk_sys) begin
      if (!nrst || fst_q != KWUP_F_SAMPLE || f_tick) begin
         fcnt_q <= 16'h0000;
      end else begin
         fcnt_q <= fcnt_q + 16'h0001;
      end
   end

   // three samples per filter period
   always_ff @(posedge clk_sys) begin
      if (!nrst || fst_q != KWUP_F_SAMPLE) begin
         fsmp_q <= 2'b00;
      end else if (f_tick) begin
         fsmp_q <= fsmp_q + 2'b01;
      end
   end

   // a pin that falls while the filter runs joins the vote
   always_ff @(posedge clk_sys) begin
      if (!nrst || !stop_q || fst_q == KWUP_F_DECIDE) begin
         g_arm_q <= KWUP_RST_BYTE;
      end else begin
         g_arm_q <= g_arm_q | g_new;
      end
   end

   // port H pins share the same filter
   always_ff @(posedge clk_sys) begin
      if (!nrst || !stop_q || fst_q == KWUP_F_DECIDE) begin
         h_arm_q <= KWUP_RST_BYTE;
      end else begin
         h_arm_q <= h_arm_q | h_new;
      end
   end

   // per-pin two-bit low counters for the vote
   logic [1:0] g_cnt_q [8];
   logic [1:0] h_cnt_q [8];
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_vote
         always_ff @(posedge clk_sys) begin
            if (!nrst || fst_q == KWUP_F_IDLE) begin
               g_cnt_q[i] <= 2'b00;
               h_cnt_q[i] <= 2'b00;
            end else if (fst_q == KWUP_F_SAMPLE && f_tick) begin
               if (g_arm_q[i] && !g_pin_in[i]) g_cnt_q[i] <= g_cnt_q[i] + 2'b01;
               if (h_arm_q[i] && !h_pin_in[i]) h_cnt_q[i] <= h_cnt_q[i] + 2'b01;
            end
         end
         assign g_fok[i] = fst_q == KWUP_F_DECIDE && g_cnt_q[i] >= 2'd2;
         assign h_fok[i] = fst_q == KWUP_F_DECIDE && h_cnt_q[i] >= 2'd2;
      end
   endgenerate

   // edge detection on synchronous pins; reset loads high, so a pin low after reset gives an edge
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         g_prev_q <= 8'hff;
      end else begin
         g_prev_q <= g_pin_in;
      end
   end

   // port H edges
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         h_prev_q <= 8'hff;
      end else begin
         h_prev_q <= h_pin_in;
      end
   end
   assign g_fall = g_prev_q & ~g_pin_in;
   assign h_fall = h_prev_q & ~h_pin_in;

   // events: direct outside STOP, filtered inside
   always_comb begin
      g_ev = stop_q ? g_fok : g_fall;
      h_ev = stop_q ? h_fok : h_fall;
      g_ev[KWUP_SCL_BIT] = 1'b0;
      if (i2c_sel && !g_pin_in[KWUP_SCL_BIT]) g_ev[KWUP_SDA_BIT] = 1'b0;
   end

   // flag next state: clear first, then set, so an edge beats the clear
   always_comb begin
      g_wfl_d = g_wfl_q;
      if (bus.wr && hit(KWUP_ADDR_G_WFL)) g_wfl_d = g_wfl_q & ~bus.wdata;
      g_wfl_d = (g_wfl_d | g_ev) & KWUP_G_WAKE_MASK;
   end

   // port H flags
   always_comb begin
      h_wfl_d = h_wfl_q;
      if (bus.wr && hit(KWUP_ADDR_H_WFL)) h_wfl_d = h_wfl_q & ~bus.wdata;
      h_wfl_d = h_wfl_d | h_ev;
   end

   // flag registers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         g_wfl_q <= KWUP_RST_BYTE;
      end else begin
         g_wfl_q <= g_wfl_d;
      end
   end

   // port H flag register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         h_wfl_q <= KWUP_RST_BYTE;
      end else begin
         h_wfl_q <= h_wfl_d;
      end
   end

   // pending requests per port from next flag state
   assign g_pend = armed(g_wfl_d, g_wen_q, KWUP_G_WAKE_MASK) != 8'h00;
   assign h_pend = armed(h_wfl_d, h_wen_q, KWUP_H_WAKE_MASK) != 8'h00;

   // one shared wake request for all pins of both ports except port G pin 7
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         wake_irq <= 1'b0;
      end else begin
         wake_irq <= g_pend || h_pend;
      end
   end

   // read decode
   function automatic logic [7:0] reg_value(input logic [7:0] a);
      case (a)
         KWUP_ADDR_G_DATA: return g_data_q;
         KWUP_ADDR_H_DATA: return h_data_q;
         KWUP_ADDR_G_DIR: return g_dir_q;
         KWUP_ADDR_H_DIR: return h_dir_q;
         KWUP_ADDR_G_WEN: return g_wen_q;
         KWUP_ADDR_H_WEN: return h_wen_q;
         KWUP_ADDR_G_WFL: return g_wfl_q & KWUP_G_WAKE_MASK;
         KWUP_ADDR_H_WFL: return h_wfl_q;
         KWUP_ADDR_MODE: return {7'h00, stop_q};
         default: return 8'h00;
      endcase
   endfunction

   // read port, data one cycle after strobe, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (!nrst || !bus.rd) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= reg_value(bus.addr);
      end
   end

   // port G drivers; start detection makes pins 6 and 7 open-drain
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         g_pins.out <= KWUP_RST_BYTE;
         g_pins.oe <= KWUP_RST_BYTE;
      end else begin
         g_pins.out <= g_data_q;
         g_pins.oe <= g_dir_q;
         g_pins.oe[KWUP_SDA_BIT] <= drive_en(g_dir_q[KWUP_SDA_BIT],
               g_data_q[KWUP_SDA_BIT], i2c_sel);
         g_pins.oe[KWUP_SCL_BIT] <= drive_en(g_dir_q[KWUP_SCL_BIT],
               g_data_q[KWUP_SCL_BIT], i2c_sel);
      end
   end

   // port H drivers
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         h_pins.out <= KWUP_RST_BYTE;
         h_pins.oe <= KWUP_RST_BYTE;
      end else begin
         h_pins.out <= h_data_q;
         h_pins.oe <= h_dir_q;
      end
   end

   // pulls on input pins only, sense from the select pin
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         g_pins.pull_up <= KWUP_RST_BYTE;
         g_pins.pull_dn <= KWUP_RST_BYTE;
      end else begin
         g_pins.pull_up <= pull_mask(g_pull_select_pin, 1'b1, g_dir_q);
         g_pins.pull_dn <= pull_mask(g_pull_select_pin, 1'b0, g_dir_q);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         h_pins.pull_up <= KWUP_RST_BYTE;
         h_pins.pull_dn <= KWUP_RST_BYTE;
      end else begin
         h_pins.pull_up <= pull_mask(h_pull_select_pin, 1'b1, h_dir_q);
         h_pins.pull_dn <= pull_mask(h_pull_select_pin, 1'b0, h_dir_q);
      end
   end
endmodule

/* File: test/kwup_pin_model.sv */
// pin side model: outside sources against the port drivers
`timescale 1ns/1ns
module kwup_pin_model
   import kwup_pkg::*;
(
   input wire kwup_pins_t pins,
   input wire logic [7:0] ext,
   output logic [7:0] level
);
   // driven bits show the port, released bits the outside source
   assign level = (pins.oe & pins.out) | (~pins.oe & ext);
endmodule

/* File: test/kwup_ports_properties.sv */
// checker for the key wake-up port block
`timescale 1ns/1ns
module kwup_ports_properties
   import kwup_pkg::*;
#(
   parameter int FOSC_CYC = KWUP_FOSC_CYC
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire kwup_bus_t bus,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] g_pin_in,
   input wire logic [7:0] h_pin_in,
   input wire logic g_pull_select_pin,
   input wire logic h_pull_select_pin,
   input wire kwup_pins_t g_pins,
   input wire kwup_pins_t h_pins,
   input wire logic wake_irq
);
   logic [7:0] g_en_q;
   logic [7:0] h_en_q;
   logic stop_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // shadow of enable and mode writes
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         g_en_q <= KWUP_RST_BYTE;
         h_en_q <= KWUP_RST_BYTE;
         stop_q <= 1'b0;
      end else if (bus.wr) begin
         case (bus.addr)
            KWUP_ADDR_G_WEN: g_en_q <= bus.wdata;
            KWUP_ADDR_H_WEN: h_en_q <= bus.wdata;
            KWUP_ADDR_MODE: stop_q <= bus.wdata[KWUP_STOP_BIT];
            default: ;
         endcase
      end
   end
   sequence s_h_fall;
      !stop_q && |(h_en_q & $past(h_pin_in) & ~h_pin_in);
   endsequence
   sequence s_g_fall;
      !stop_q && |(g_en_q[5:0] & $past(g_pin_in[5:0]) & ~g_pin_in[5:0]);
   endsequence
   property p_flag7_zero;
      bus.rd && bus.addr == KWUP_ADDR_G_WFL |=> !rd_data[7];
   endproperty
   a_flag7_zero: assert property (p_flag7_zero) else $error("flag bit 7 read high");
   property p_pull_excl;
      ((g_pins.pull_up & g_pins.pull_dn) | (h_pins.pull_up & h_pins.pull_dn)) == 8'h00;
   endproperty
   a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
   property p_pull_dir;
      $stable(h_pull_select_pin) [*2] |->
         (h_pull_select_pin ? h_pins.pull_dn : h_pins.pull_up) == 8'h00;
   endproperty
   a_pull_dir: assert property (p_pull_dir) else $error("pull against select");
   property p_pull_in;
      ((g_pins.pull_up | g_pins.pull_dn) & g_pins.oe) == 8'h00;
   endproperty
   a_pull_in: assert property (p_pull_in) else $error("pull on output pin");
   property p_open_drain;
      g_en_q[KWUP_I2C_SEL_BIT] [*3] |-> (g_pins.oe[7:6] & g_pins.out[7:6]) == 2'b00;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("start pins driven high");
   property p_irq_off;
      (g_en_q[6:0] == 7'h00 && h_en_q == 8'h00) [*3] |-> !wake_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("request with no enable");
   property p_h_fall;
      s_h_fall |-> ##[1:3] wake_irq;
   endproperty
   a_h_fall: assert property (p_h_fall) else $error("h fall gave no request");
   property p_g_fall;
      s_g_fall |-> ##[1:3] wake_irq;
   endproperty
   a_g_fall: assert property (p_g_fall) else $error("g fall gave no request");
endmodule
bind kwup_ports kwup_ports_properties #(.FOSC_CYC(FOSC_CYC)) i_props (.clk_sys(clk_sys),
   .nrst(nrst), .bus(bus), .rd_data(rd_data), .g_pin_in(g_pin_in), .h_pin_in(h_pin_in),
   .g_pull_select_pin(g_pull_select_pin), .h_pull_select_pin(h_pull_select_pin),
   .g_pins(g_pins), .h_pins(h_pins), .wake_irq(wake_irq));

/* File: test/tb.sv */
// self-checking bench for the key wake-up port block
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb;
   import kwup_pkg::*;
   logic clk_sys;
   logic nrst;
   kwup_bus_t bus;
   logic [7:0] rd_data;
   logic [7:0] g_pin_in;
   logic [7:0] h_pin_in;
   logic [7:0] g_ext;
   logic [7:0] h_ext;
   logic g_pull_select_pin;
   logic h_pull_select_pin;
   kwup_pins_t g_pins;
   kwup_pins_t h_pins;
   logic wake_irq;
   int fail_count;
   int compares;
   kwup_ports #(.FOSC_CYC(9)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
      .rd_data(rd_data), .g_pin_in(g_pin_in), .h_pin_in(h_pin_in),
      .g_pull_select_pin(g_pull_select_pin), .h_pull_select_pin(h_pull_select_pin),
      .g_pins(g_pins), .h_pins(h_pins), .wake_irq(wake_irq));
   kwup_pin_model i_gmod (.pins(g_pins), .ext(g_ext), .level(g_pin_in));
   kwup_pin_model i_hmod (.pins(h_pins), .ext(h_ext), .level(h_pin_in));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus <= '0;
      #1;
      `CHK("read data", e, rd_data)
   endtask
   task automatic drive(input logic [7:0] g, input logic [7:0] h, input int n);
      @(posedge clk_sys);
      g_ext <= g;
      h_ext <= h;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic chk_irq(input logic e);
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("wake request", e, wake_irq)
   endtask
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // whole sequence takes under 1000 cycles
   initial begin
      #200_000;
      fail_count++;
      wrap_up();
   end
   initial begin
      nrst = 1'b0;
      bus = '0;
      g_ext = 8'hff;
      h_ext = 8'hff;
      g_pull_select_pin = 1'b1;
      h_pull_select_pin = 1'b0;
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int a = 'h28; a < 'h32; a++) begin
         rd(8'(a), 8'h00);
      end
      wr(KWUP_ADDR_G_DATA, 8'ha5);
      wr(KWUP_ADDR_G_DIR, 8'h0f);
      wr(KWUP_ADDR_H_DATA, 8'h3c);
      rd(KWUP_ADDR_G_DATA, 8'ha5);
      rd(KWUP_ADDR_H_DATA, 8'h3c);
      `CHK("g drive", 8'h0f, g_pins.oe)
      `CHK("g level", 8'hf5, g_pin_in)
      `CHK("h drive", 8'h00, h_pins.oe)
      `CHK("h out", 8'h3c, h_pins.out)
      `CHK("g pull up", 8'hf0, g_pins.pull_up)
      h_pull_select_pin <= 1'b1;
      wr(KWUP_ADDR_G_WFL, 8'hff);
      wr(KWUP_ADDR_H_WEN, 8'hff);
      wr(KWUP_ADDR_G_WEN, 8'h7f);
      drive(8'h1f, 8'hf7, 2);
      rd(KWUP_ADDR_G_WFL, 8'h60);
      rd(KWUP_ADDR_H_WFL, 8'h08);
      chk_irq(1'b1);
      wr(KWUP_ADDR_H_WFL, 8'h00);
      rd(KWUP_ADDR_H_WFL, 8'h08);
      wr(KWUP_ADDR_H_WFL, 8'h08);
      rd(KWUP_ADDR_H_WFL, 8'h00);
      chk_irq(1'b1);
      wr(KWUP_ADDR_G_WEN, 8'h00);
      chk_irq(1'b0);
      drive(8'hff, 8'hff, 2);
      wr(KWUP_ADDR_G_DIR, 8'hc0);
      wr(KWUP_ADDR_G_DATA, 8'h40);
      wr(KWUP_ADDR_G_WEN, 8'hc0);
      wr(KWUP_ADDR_G_WFL, 8'hff);
      drive(8'hbf, 8'hff, 2);
      rd(KWUP_ADDR_G_WFL, 8'h00);
      drive(8'hff, 8'hff, 2);
      wr(KWUP_ADDR_G_DATA, 8'hc0);
      drive(8'hbf, 8'hff, 2);
      rd(KWUP_ADDR_G_WFL, 8'h40);
      chk_irq(1'b1);
      wr(KWUP_ADDR_G_WEN, 8'h00);
      wr(KWUP_ADDR_G_WFL, 8'hff);
      wr(KWUP_ADDR_MODE, 8'h01);
      drive(8'hff, 8'hfe, 1);
      drive(8'hff, 8'hff, 40);
      rd(KWUP_ADDR_H_WFL, 8'h00);
      drive(8'hff, 8'hfe, 40);
      rd(KWUP_ADDR_H_WFL, 8'h01);
      drive(8'hff, 8'hff, 2);
      wr(KWUP_ADDR_MODE, 8'h00);
      wr(KWUP_ADDR_H_WFL, 8'hff);
      chk_irq(1'b0);
      wrap_up();
   end
endmodule
